// ---- src/iscc_regs.svh ----
// register map and field constants of the sensor capture controller
// assumes a 32-bit APB slave with word-aligned registers
`ifndef ISCC_REGS_SVH
`define ISCC_REGS_SVH
// ****************************************
// offsets
// ****************************************
`define ISCC_OFS_SYNC_CTRL   12'h000
`define ISCC_OFS_MODE        12'h004
`define ISCC_OFS_PULSE_WIDTH 12'h008
`define ISCC_OFS_FRAME_SIZE  12'h00c
`define ISCC_OFS_ADDR_HIGH   12'h010
`define ISCC_OFS_ADDR_LOW    12'h014
`define ISCC_OFS_LINE_THRESH 12'h018
`define ISCC_OFS_STATUS      12'h01c
`define ISCC_OFS_ACTIVE_ADDR 12'h020
`define ISCC_OFS_DEFECT_IDX  12'h024
`define ISCC_OFS_DEFECT_DATA 12'h028
// ****************************************
// fields
// ****************************************
`define ISCC_BIT_RUN         0
`define ISCC_BIT_WEN         1
`define ISCC_BIT_DIR_OUT     0
`define ISCC_BIT_VS_POL      1
`define ISCC_FMT_LSB         2
`define ISCC_BIT_EMB_SYNC    4
`define ISCC_BIT_DATA_POL    5
`define ISCC_FMT_RAW         2'h0
// ****************************************
// reset values and sizes
// ****************************************
`define ISCC_RST_SYNC_CTRL   2'h0
`define ISCC_RST_WORD        32'h0000_0000
`define ISCC_DEFECT_DEPTH    16
`define ISCC_SYNC_STAGES     2
`endif

// ---- src/iscc_pkg.sv ----
// types of the sensor capture controller
// state encodings and count width are literals here; nothing is taken from iscc_regs.svh
package iscc_pkg;
    typedef enum logic [2:0] {
        ISCC_IDLE      = 3'b001,
        ISCC_WAIT_SYNC = 3'b010,
        ISCC_CAPTURE   = 3'b100
    } iscc_state_e;
    typedef logic [15:0] iscc_count_t;
endpackage

// ---- src/iscc_capture.sv ----
// sensor capture controller: APB registers, sync timing, capture path
// assumes imager pins asynchronous to pclk, pixel clock well below pclk/2
`timescale 1ns/100ps
`include "iscc_regs.svh"

module iscc_capture
    import iscc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pixel_clock,
    input  wire logic [11:0] pixel_data,
    input  wire logic        horizontal_sync_in,
    output logic             horizontal_sync_out,
    output logic             horizontal_sync_oe,
    input  wire logic        vertical_sync_in,
    output logic             vertical_sync_out,
    output logic             vertical_sync_oe,
    output logic             image_pipe_valid,
    output logic      [11:0] image_pipe_data,
    output logic             mem_wr_valid,
    output logic      [31:0] mem_wr_addr,
    output logic      [15:0] mem_wr_data,
    output logic             line_interrupt_a,
    output logic             line_interrupt_b
);
    // ****************************************
    // registers
    // ****************************************
    logic        run_ff, wen_ff, dir_ff, vs_pol_ff, emb_ff, dpol_ff;
    logic [1:0]  fmt_ff;
    iscc_count_t hpw_ff, vpw_ff, ppl_ff, lpf_ff, thr_a_ff, thr_b_ff;
    logic [15:0] addr_hi_ff, addr_lo_ff;
    logic [3:0]  dft_idx_ff;
    logic [31:0] dft_mem [`ISCC_DEFECT_DEPTH];
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, pslverr_ff, nxt_err;
    iscc_state_e state_ff, nxt_state;
    iscc_count_t h_cnt_ff, v_cnt_ff, line_cnt_ff, frame_cnt_ff;
    logic [31:0] base_ff, cur_addr_ff;
    logic        wen_act_ff;
    logic        hs_out_ff, vs_out_ff, oe_ff;
    logic        hs_prev_ff, vs_prev_ff, px_prev_ff;
    logic        pipe_v_ff, mem_v_ff, int_a_ff, int_b_ff;
    logic [11:0] pipe_d_ff;
    logic [15:0] mem_d_ff;
    logic [31:0] mem_a_ff;
    logic [14:0] meta_ff, sync_ff;

    wire wr_ok  = psel & penable & pready_ff & pwrite;
    wire rd_cyc = psel & penable & ~pready_ff;

    // ****************************************
    // apb slave, one wait state
    // ****************************************
    always_comb begin
        nxt_prdata = `ISCC_RST_WORD;
        nxt_err    = 1'b0;
        unique case (paddr)
            `ISCC_OFS_SYNC_CTRL:   nxt_prdata = {30'h0, wen_ff, run_ff};
            `ISCC_OFS_MODE:        nxt_prdata = {26'h0, dpol_ff, emb_ff,
                                                 fmt_ff, vs_pol_ff, dir_ff};
            `ISCC_OFS_PULSE_WIDTH: nxt_prdata = {vpw_ff, hpw_ff};
            `ISCC_OFS_FRAME_SIZE:  nxt_prdata = {lpf_ff, ppl_ff};
            `ISCC_OFS_ADDR_HIGH:   nxt_prdata = {16'h0, addr_hi_ff};
            `ISCC_OFS_ADDR_LOW:    nxt_prdata = {16'h0, addr_lo_ff};
            `ISCC_OFS_LINE_THRESH: nxt_prdata = {thr_b_ff, thr_a_ff};
            `ISCC_OFS_STATUS:      nxt_prdata = {frame_cnt_ff, line_cnt_ff};
            `ISCC_OFS_ACTIVE_ADDR: nxt_prdata = cur_addr_ff;
            `ISCC_OFS_DEFECT_IDX:  nxt_prdata = {28'h0, dft_idx_ff};
            `ISCC_OFS_DEFECT_DATA: nxt_prdata = dft_mem[dft_idx_ff];
            default:               nxt_err    = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= `ISCC_RST_WORD;
        end else begin
            pready_ff  <= rd_cyc;
            pslverr_ff <= rd_cyc & nxt_err;
            if (rd_cyc && !pwrite) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    // control registers return to reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {wen_ff, run_ff} <= `ISCC_RST_SYNC_CTRL;
            {dir_ff, vs_pol_ff, emb_ff, dpol_ff} <= 4'h0;
            fmt_ff     <= `ISCC_FMT_RAW;
            {hpw_ff, vpw_ff, ppl_ff, lpf_ff} <= 64'h0;
            {thr_a_ff, thr_b_ff} <= `ISCC_RST_WORD;
            {addr_hi_ff, addr_lo_ff} <= `ISCC_RST_WORD;
            dft_idx_ff <= 4'h0;
        end else if (wr_ok) begin
            unique case (paddr)
                `ISCC_OFS_SYNC_CTRL: begin
                    run_ff <= pwdata[`ISCC_BIT_RUN];
                    wen_ff <= pwdata[`ISCC_BIT_WEN];
                end
                `ISCC_OFS_MODE: begin
                    dir_ff    <= pwdata[`ISCC_BIT_DIR_OUT];
                    vs_pol_ff <= pwdata[`ISCC_BIT_VS_POL];
                    fmt_ff    <= pwdata[`ISCC_FMT_LSB +: 2];
                    emb_ff    <= pwdata[`ISCC_BIT_EMB_SYNC];
                    dpol_ff   <= pwdata[`ISCC_BIT_DATA_POL];
                end
                `ISCC_OFS_PULSE_WIDTH: {vpw_ff, hpw_ff} <= pwdata;
                `ISCC_OFS_FRAME_SIZE:  {lpf_ff, ppl_ff} <= pwdata;
                `ISCC_OFS_ADDR_HIGH:   addr_hi_ff <= pwdata[15:0];
                `ISCC_OFS_ADDR_LOW:    addr_lo_ff <= pwdata[15:0];
                `ISCC_OFS_LINE_THRESH: {thr_b_ff, thr_a_ff} <= pwdata;
                `ISCC_OFS_DEFECT_IDX:  dft_idx_ff <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // defect table RAM: no reset, keeps contents over reset
    always_ff @(posedge pclk) begin
        if (wr_ok && paddr == `ISCC_OFS_DEFECT_DATA) begin
            dft_mem[dft_idx_ff] <= pwdata;
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 15'h0;
            sync_ff <= 15'h0;
        end else begin
            meta_ff <= {pixel_data, vertical_sync_in,
                        horizontal_sync_in, pixel_clock};
            sync_ff <= meta_ff;
        end
    end

    wire px_rise  = sync_ff[0] & ~px_prev_ff;
    wire hs_lvl   = dir_ff ? hs_out_ff : sync_ff[1];
    wire vs_lvl   = dir_ff ? vs_out_ff : sync_ff[2];
    wire hs_rise  = hs_lvl & ~hs_prev_ff;
    wire vs_start = vs_pol_ff ? (~vs_lvl & vs_prev_ff)
                              : (vs_lvl & ~vs_prev_ff);
    wire fr_start = (state_ff == ISCC_IDLE && run_ff && dir_ff) ||
                    (state_ff != ISCC_IDLE && run_ff && vs_start);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {px_prev_ff, hs_prev_ff, vs_prev_ff} <= 3'h0;
        end else begin
            {px_prev_ff, hs_prev_ff, vs_prev_ff} <= {sync_ff[0], hs_lvl,
                                                     vs_lvl};
        end
    end

    // ****************************************
    // frame state
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ISCC_IDLE: begin
                if (run_ff) begin
                    nxt_state = dir_ff ? ISCC_CAPTURE : ISCC_WAIT_SYNC;
                end
            end
            ISCC_WAIT_SYNC: begin
                if (vs_start) begin
                    nxt_state = ISCC_CAPTURE;
                end
            end
            ISCC_CAPTURE: nxt_state = ISCC_CAPTURE;
            default:      nxt_state = ISCC_IDLE;
        endcase
        if (!run_ff) begin
            nxt_state = ISCC_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ISCC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // master sync generator
    // ****************************************
    wire         h_wrap  = (h_cnt_ff + 16'h1 >= ppl_ff);
    wire         v_wrap  = (v_cnt_ff + 16'h1 >= lpf_ff);
    iscc_count_t nxt_h, nxt_v;
    assign nxt_h = h_wrap ? 16'h0 : h_cnt_ff + 16'h1;
    assign nxt_v = !h_wrap ? v_cnt_ff : (v_wrap ? 16'h0 : v_cnt_ff + 16'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_cnt_ff  <= 16'h0;
            v_cnt_ff  <= 16'h0;
            hs_out_ff <= 1'b0;
            vs_out_ff <= 1'b0;
            oe_ff     <= 1'b0;
        end else begin
            oe_ff <= dir_ff & run_ff;
            if (!run_ff || !dir_ff) begin
                h_cnt_ff  <= 16'h0;
                v_cnt_ff  <= 16'h0;
                hs_out_ff <= 1'b0;
                vs_out_ff <= vs_pol_ff;
            end else if (px_rise) begin
                h_cnt_ff  <= nxt_h;
                v_cnt_ff  <= nxt_v;
                hs_out_ff <= nxt_h < hpw_ff;
                vs_out_ff <= (nxt_v < vpw_ff) ^ vs_pol_ff;
            end
        end
    end

    // ****************************************
    // line interrupt counters
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_cnt_ff  <= 16'h0;
            frame_cnt_ff <= 16'h0;
            int_a_ff     <= 1'b0;
            int_b_ff     <= 1'b0;
        end else begin
            int_a_ff <= 1'b0;
            int_b_ff <= 1'b0;
            if (state_ff == ISCC_IDLE) begin
                line_cnt_ff <= 16'h0;
            end else if (vs_start) begin
                line_cnt_ff  <= 16'h0;
                frame_cnt_ff <= frame_cnt_ff + 16'h1;
            end else if (hs_rise) begin
                line_cnt_ff <= line_cnt_ff + 16'h1;
                int_a_ff    <= (line_cnt_ff + 16'h1 == thr_a_ff);
                int_b_ff    <= (line_cnt_ff + 16'h1 == thr_b_ff);
            end
        end
    end

    // ****************************************
    // address shadow and capture path
    // ****************************************
    // address latched only at frame start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_ff     <= `ISCC_RST_WORD;
            cur_addr_ff <= `ISCC_RST_WORD;
            wen_act_ff  <= 1'b0;
        end else if (!run_ff) begin
            wen_act_ff  <= 1'b0;
        end else if (fr_start) begin
            base_ff     <= {addr_hi_ff, addr_lo_ff};
            cur_addr_ff <= {addr_hi_ff, addr_lo_ff};
            wen_act_ff  <= wen_ff;
        end else if (mem_v_ff) begin
            cur_addr_ff <= cur_addr_ff + 32'h1;
        end
    end

    wire         cap   = (state_ff == ISCC_CAPTURE) && run_ff && px_rise;
    wire         raw   = (fmt_ff == `ISCC_FMT_RAW) && !emb_ff;
    wire [11:0]  px_in = sync_ff[14:3] ^ {12{dpol_ff & raw}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pipe_v_ff <= 1'b0;
            mem_v_ff  <= 1'b0;
            pipe_d_ff <= 12'h0;
            mem_d_ff  <= 16'h0;
            mem_a_ff  <= `ISCC_RST_WORD;
        end else begin
            pipe_v_ff <= cap & raw;
            mem_v_ff  <= cap & wen_act_ff & ~fr_start;
            if (cap) begin
                pipe_d_ff <= px_in;
                mem_d_ff  <= {4'h0, px_in};
                mem_a_ff  <= cur_addr_ff;
            end
        end
    end

    assign prdata              = prdata_ff;
    assign pready              = pready_ff;
    assign pslverr             = pslverr_ff;
    assign horizontal_sync_out = hs_out_ff;
    assign vertical_sync_out   = vs_out_ff;
    assign horizontal_sync_oe  = oe_ff;
    assign vertical_sync_oe    = oe_ff;
    assign image_pipe_valid    = pipe_v_ff;
    assign image_pipe_data     = pipe_d_ff;
    assign mem_wr_valid        = mem_v_ff;
    assign mem_wr_addr         = mem_a_ff;
    assign mem_wr_data         = mem_d_ff;
    assign line_interrupt_a    = int_a_ff;
    assign line_interrupt_b    = int_b_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_cleared: assert property ($past(!presetn) |-> !run_ff && !wen_ff)
        else $error("run or write enable set after reset");
    a_idle_silent: assert property (state_ff == ISCC_IDLE |=> !mem_wr_valid && !image_pipe_valid)
        else $error("capture output while idle");
    a_master_drive: assert property (dir_ff && run_ff && $past(dir_ff && run_ff) |-> horizontal_sync_oe && vertical_sync_oe)
        else $error("master mode not driving sync");
    a_slave_release: assert property (!dir_ff && $past(!dir_ff) |-> !horizontal_sync_oe && !vertical_sync_oe)
        else $error("slave mode drives sync");
    a_slave_wait: assert property (state_ff == ISCC_WAIT_SYNC && !vs_start && run_ff |=> state_ff == ISCC_WAIT_SYNC)
        else $error("slave capture began without vertical sync");
    a_addr_shadow: assert property (!fr_start && run_ff |=> $stable(base_ff))
        else $error("address changed outside frame start");
    a_raw_only: assert property (image_pipe_valid |-> $past(raw))
        else $error("non-RAW data sent to image pipe");
    a_stop_abandon: assert property ($fell(run_ff) |-> ##1 state_ff == ISCC_IDLE && !mem_wr_valid && !image_pipe_valid)
        else $error("frame continued after run cleared");
    a_line_int: assert property (line_interrupt_a |-> $past(hs_rise) && line_cnt_ff == thr_a_ff)
        else $error("line interrupt at wrong count");
endmodule

// ---- verification/iscc_imager_model.sv ----
// behavioural imager: pixel clock, pixel bus and slave-mode sync lines
// assumes the bench gates it with frame_en; clock stands still when low
`timescale 1ns/100ps
module iscc_imager_model #(
    parameter int PPL = 8,
    parameter int LPF = 4
) (
    input  wire logic        frame_en,
    output logic             pixel_clock,
    output logic      [11:0] pixel_data,
    output logic             hsync,
    output logic             vsync
);
    int px = PPL - 1;
    int ln = LPF - 1;

    initial begin
        pixel_clock = 1'b0;
        pixel_data  = 12'h000;
        hsync       = 1'b0;
        vsync       = 1'b0;
    end

    // ****************************************
    // pixel clock, 160 ns, only within frames
    // ****************************************
    always begin
        #80;
        if (frame_en)
            pixel_clock = ~pixel_clock;
        else
            pixel_clock = 1'b0;
    end

    // ****************************************
    // frame timing, launched on falling edge
    // ****************************************
    always @(negedge pixel_clock) begin
        px = (px == PPL - 1) ? 0 : px + 1;
        if (px == 0)
            ln = (ln == LPF - 1) ? 0 : ln + 1;
        hsync      = (px < 2);
        vsync      = (ln == 0);
        pixel_data = pixel_data + 12'h001;
    end
endmodule

// ---- verification/image_sensor_capture_control_tb_top.sv ----
// bench for the sensor capture controller: APB tasks and imager model
// assumes iscc_capture and iscc_imager_model compiled before it
`timescale 1ns/100ps
`include "iscc_regs.svh"
module image_sensor_capture_control_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, pixel_data;
    logic [31:0] pwdata, prdata, mem_wr_addr, last_addr, rdata;
    logic [15:0] wdat;
    logic [11:0] ip_data;
    logic        pixel_clock, frame_en, im_hs, im_vs, err;
    logic        hs_out, hs_oe, vs_out, vs_oe, ip_valid, mem_wr_valid;
    logic        line_a, line_b;
    int          errors = 0;
    int          checks = 0;
    int          wr_cnt = 0, ip_cnt = 0, la_cnt = 0, lb_cnt = 0;
    int          n, m, a, b, k;

    iscc_capture iscc_capture_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pixel_clock(pixel_clock),
        .pixel_data(pixel_data),
        .horizontal_sync_in(hs_oe ? hs_out : im_hs),
        .horizontal_sync_out(hs_out), .horizontal_sync_oe(hs_oe),
        .vertical_sync_in(vs_oe ? vs_out : im_vs),
        .vertical_sync_out(vs_out), .vertical_sync_oe(vs_oe),
        .image_pipe_valid(ip_valid), .image_pipe_data(ip_data),
        .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(wdat), .line_interrupt_a(line_a),
        .line_interrupt_b(line_b));

    iscc_imager_model iscc_imager_model_inst (
        .frame_en(frame_en), .pixel_clock(pixel_clock),
        .pixel_data(pixel_data), .hsync(im_hs), .vsync(im_vs));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ****************************************
    // output monitor
    // ****************************************
    always @(posedge pclk) begin
        if (mem_wr_valid === 1'b1) begin
            wr_cnt    <= wr_cnt + 1;
            last_addr <= mem_wr_addr;
        end
        if (ip_valid === 1'b1) ip_cnt <= ip_cnt + 1;
        if (line_a === 1'b1) la_cnt <= la_cnt + 1;
        if (line_b === 1'b1) lb_cnt <= lb_cnt + 1;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic results();
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic apb(input logic wr, input logic [11:0] ad,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            errors++;
            results();
        end
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask

    task automatic rd_chk(input logic [11:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        cmp_bit(err, 1'b0);
        cmp_word(rdata, exp);
    endtask

    function automatic int cnt(input int sel);
        case (sel)
            0: return wr_cnt;
            1: return ip_cnt;
            2: return la_cnt;
            default: return lb_cnt;
        endcase
    endfunction

    task automatic wait_cnt(input int sel, input int target);
        int i;
        checks++;
        for (i = 0; i < 3000; i++) begin
            @(posedge pclk);
            if (cnt(sel) >= target) break;
        end
        if (i == 3000) begin
            errors++;
            $display("unexpected at %0t: count %h expected %h", $time,
                     cnt(sel), target);
            results();
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        frame_en = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 7; k++)
            rd_chk(12'(4 * k), `ISCC_RST_WORD);
        apb(1'b0, 12'h030, 32'h0);
        cmp_bit(err, 1'b1);
        cmp_word(rdata, 32'h0);
        // master mode, raw
        wr(`ISCC_OFS_MODE, 32'h1);
        wr(`ISCC_OFS_PULSE_WIDTH, 32'h0001_0002);
        wr(`ISCC_OFS_FRAME_SIZE, 32'h0004_0008);
        wr(`ISCC_OFS_LINE_THRESH, 32'h0002_0001);
        wr(`ISCC_OFS_ADDR_HIGH, 32'h1);
        wr(`ISCC_OFS_ADDR_LOW, 32'h100);
        frame_en <= 1'b1;
        n = wr_cnt; m = ip_cnt; a = la_cnt; b = lb_cnt;
        wr(`ISCC_OFS_SYNC_CTRL, 32'h3);
        wait_cnt(0, n + 1);
        cmp_bit(hs_oe, 1'b1);
        cmp_bit(vs_oe, 1'b1);
        cmp_word({8'h0, last_addr[31:8]}, 32'h101);
        wait_cnt(1, m + 1);
        cmp_word({16'h0, wdat}, {20'h0, ip_data});
        wait_cnt(2, a + 1);
        wait_cnt(3, b + 1);
        wr(`ISCC_OFS_ADDR_LOW, 32'h200);
        n = wr_cnt;
        wait_cnt(0, n + 1);
        cmp_word({8'h0, last_addr[31:8]}, 32'h101);
        wait_cnt(0, n + 40);
        cmp_word({8'h0, last_addr[31:8]}, 32'h102);
        wr(`ISCC_OFS_SYNC_CTRL, 32'h0);
        repeat (4) @(posedge pclk);
        cmp_bit(hs_oe, 1'b0);
        n = wr_cnt;
        repeat (200) @(posedge pclk);
        cmp_word(32'(wr_cnt - n), 32'h0);
        // ycc input, 8 bit
        wr(`ISCC_OFS_MODE, 32'h9);
        m = ip_cnt; n = wr_cnt;
        wr(`ISCC_OFS_SYNC_CTRL, 32'h3);
        wait_cnt(0, n + 5);
        cmp_word(32'(ip_cnt - m), 32'h0);
        wr(`ISCC_OFS_SYNC_CTRL, 32'h0);
        // slave mode waits for the imager's frame
        frame_en <= 1'b0;
        wr(`ISCC_OFS_MODE, 32'h0);
        n = wr_cnt;
        wr(`ISCC_OFS_SYNC_CTRL, 32'h3);
        repeat (300) @(posedge pclk);
        cmp_word(32'(wr_cnt - n), 32'h0);
        cmp_bit(vs_oe, 1'b0);
        frame_en <= 1'b1;
        wait_cnt(0, n + 1);
        cmp_word({8'h0, last_addr[31:8]}, 32'h102);
        // reset in mid-run keeps the defect table
        wr(`ISCC_OFS_DEFECT_IDX, 32'h3);
        wr(`ISCC_OFS_DEFECT_DATA, 32'h5a5a_1234);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`ISCC_OFS_SYNC_CTRL, 32'h0);
        rd_chk(`ISCC_OFS_MODE, 32'h0);
        wr(`ISCC_OFS_DEFECT_IDX, 32'h3);
        rd_chk(`ISCC_OFS_DEFECT_DATA, 32'h5a5a_1234);
        results();
    end
endmodule
